// [rtl/dramc_regs.svh]
// Timing constants and pin encodings for the DRAM page controller
`ifndef DRAMC_REGS_SVH
`define DRAMC_REGS_SVH
`define DRAMC_CLK_MHZ        200
`define DRAMC_PAUSE_US       200
`define DRAMC_PAUSE_CYC      (`DRAMC_PAUSE_US * `DRAMC_CLK_MHZ)
`define DRAMC_INIT_CYCLES    4'h8
`define DRAMC_IDLE_MS        8
`define DRAMC_IDLE_CYC       (`DRAMC_IDLE_MS * 1000 * 1000 * `DRAMC_CLK_MHZ / 1000)
`define DRAMC_ROWS           512
`define DRAMC_RFSH_INT_CYC   (`DRAMC_IDLE_CYC / `DRAMC_ROWS)
`define DRAMC_PHASE_CYC      5'h04
`define DRAMC_ADDR_W         10
`define DRAMC_ROW_MSB        9
`define DRAMC_ZERO_ADDR      10'h000
`define DRAMC_ONE_PHASE      5'h01
`define DRAMC_ONE32          32'h0000_0001
`define DRAMC_ZERO32         32'h0000_0000
`define DRAMC_ZERO4          4'h0
`define DRAMC_ZERO5          5'h00
`define DRAMC_ONE4           4'h1
`endif

// [rtl/dramc_pkg.sv]
// Types shared by the DRAM page controller
package dramc_pkg;
  typedef enum logic [8:0] {
    ST_PAUSE  = 9'h001,
    ST_INIT   = 9'h002,
    ST_IDLE   = 9'h004,
    ST_ROW    = 9'h008,
    ST_COL    = 9'h010,
    ST_PAGE   = 9'h020,
    ST_CBR    = 9'h040,
    ST_PRE    = 9'h080,
    ST_HIDDEN = 9'h100
  } dramc_state_t;
  typedef logic [9:0] dramc_addr_t;
endpackage

// [rtl/dramc_if.sv]
// Handshake between sequencer and phase timer
`timescale 1ns/10ps
`default_nettype none
interface dramc_tmr_if;
  logic start;
  logic done;
  modport ctl (output start, input done);
  modport tmr (input start, output done);
endinterface
`default_nettype wire

// [rtl/dramc_timer.sv]
// Phase timer: counts fixed strobe phase length after a start pulse
`timescale 1ns/10ps
`default_nettype none
`include "dramc_regs.svh"
module dramc_timer
  import dramc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Sequencer side
  dramc_tmr_if.tmr  tmr
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (tmr.start) begin
      cnt_nxt = `DRAMC_PHASE_CYC;
    end else if (cnt_r != `DRAMC_ZERO5) begin
      cnt_nxt = cnt_r - `DRAMC_ONE_PHASE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= `DRAMC_ZERO5;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tmr.done = (cnt_r == `DRAMC_ONE_PHASE);
endmodule // dramc_timer
`default_nettype wire

// [rtl/dramc_ctrl.sv]
// DRAM strobe controller: power-up, refresh scheduling and page accesses
// Device rules this block works to
// RL1 - Device refreshes when column strobe leads row strobe low.
// RL2 - Device takes refresh row from its counter, not the address pins.
// RL3 - Device counter steps by one after each such refresh.
// RL4 - Hidden refresh: column strobe held low after read, row strobe cycled.
// RL5 - Device keeps last read data driven during a hidden refresh.
// RL6 - Any row access refreshes that whole row.
// RL7 - Counter test: column strobe re-pulsed under low row strobe enables access.
// RL8 - In counter test the low nine row bits come from the counter.
// RL9 - In counter test the row address top bit is forced to one.
// RL10 - Page sequence opens with a normal access and row strobe held low.
// RL11 - Each column strobe pulse accesses a new column in the open row.
// RL12 - Reads and writes mix freely within one page sequence.
// RL13 - After power-up pause 200 us, then issue 8 initialization cycles.
// RL14 - After 8 ms without row strobe cycles, redo eight initialization cycles.
// RL15 - Any row strobe low-then-high cycle counts as initialization.
// RL16 - Hold both strobes high during power-up.
// RL17 - Refresh every row at least once per 8 ms, distributed.
// RL18 - Refresh covers 512 rows from the low nine address bits.
// RL19 - Device keeps read data until column strobe rises.
// RL20 - Device refresh counter is nine bits and wraps.
`timescale 1ns/10ps
`default_nettype none
`include "dramc_regs.svh"
module dramc_ctrl
  import dramc_pkg::*;
#(
  parameter int PAUSE_CYC    = `DRAMC_PAUSE_CYC,
  parameter int IDLE_CYC     = `DRAMC_IDLE_CYC,
  parameter int RFSH_INT_CYC = `DRAMC_RFSH_INT_CYC
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // User request port
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        reqWrite,
  input  wire logic [9:0]  reqRow,
  input  wire logic [9:0]  reqCol,
  input  wire logic        reqWData,
  input  wire logic        reqLast,
  output logic             rspValid,
  output logic             rspRData,
  output logic             initDone,
  // DRAM pins
  output logic             rowStrobeN,
  output logic             colStrobeN,
  output logic             writeEnN,
  output logic [9:0]       memAddr,
  output logic             memDIn,
  input  wire logic        memDOut
);
  dramc_tmr_if tmrIf();
  dramc_timer uTimer (
    .clk (clk),
    .rst (rst),
    .tmr (tmrIf)
  );

  dramc_state_t state_r, state_nxt;
  logic        ras_r, ras_nxt, cas_r, cas_nxt, we_r, we_nxt;
  logic [9:0]  addr_r, addr_nxt, colAddr_r, colAddr_nxt;
  logic        din_r, din_nxt, rd_r, rd_nxt, last_r, last_nxt;
  logic        rsp_r, rsp_nxt, rdat_r, rdat_nxt, init_r, init_nxt;
  logic        pend_r, pend_nxt, colPh_r, colPh_nxt;
  logic [3:0]  initCnt_r, initCnt_nxt;
  logic [31:0] wait_r, wait_nxt, rfsh_r, rfsh_nxt, idle_r, idle_nxt;
  logic        dq1_r, dq2_r;
  logic        rfshDue, idleExpired;

  // Read data is a pin: two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      dq1_r <= 1'b0;
      dq2_r <= 1'b0;
    end else begin
      dq1_r <= memDOut;
      dq2_r <= dq1_r;
    end
  end

  assign rfshDue = pend_r;
  assign idleExpired = (idle_r >= IDLE_CYC - 1);
  assign tmrIf.start = (state_r != state_nxt) || (colPh_r != colPh_nxt);
  // Not ready when re-init is due, else a request would be dropped
  assign reqReady = (state_r == ST_IDLE) && !rfshDue && !idleExpired ||
                    (state_r == ST_PAGE) && !rfshDue && !last_r;

  // ======
  // Pins and user outputs except reqReady straight from flops
  assign rowStrobeN = ras_r;
  assign colStrobeN = cas_r;
  assign writeEnN   = we_r;
  assign memAddr    = addr_r;
  assign memDIn     = din_r;
  assign rspValid   = rsp_r;
  assign rspRData   = rdat_r;
  assign initDone   = init_r;

  // ======
  // Sequencer
  // Address always settles one phase before the strobe that takes it
  always_comb begin
    state_nxt = state_r;
    ras_nxt = ras_r;
    cas_nxt = cas_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    colAddr_nxt = colAddr_r;
    din_nxt = din_r;
    rd_nxt = rd_r;
    last_nxt = last_r;
    rsp_nxt = 1'b0;
    rdat_nxt = rdat_r;
    init_nxt = init_r;
    pend_nxt = pend_r;
    colPh_nxt = colPh_r;
    initCnt_nxt = initCnt_r;
    wait_nxt = wait_r;
    rfsh_nxt = rfsh_r + `DRAMC_ONE32;
    idle_nxt = idle_r + `DRAMC_ONE32;
    if (!ras_r) begin
      idle_nxt = `DRAMC_ZERO32;
    end
    case (state_r)
      ST_PAUSE: begin
        ras_nxt = 1'b1; // RL16
        cas_nxt = 1'b1; // RL16
        wait_nxt = wait_r + `DRAMC_ONE32;
        if (wait_r >= PAUSE_CYC - 1) begin
          state_nxt = ST_INIT; // RL13
          initCnt_nxt = `DRAMC_ZERO4;
          colPh_nxt = 1'b0;
        end
      end
      ST_INIT: begin
        // Row-strobe-only cycles; address content is irrelevant
        if (tmrIf.done) begin
          colPh_nxt = !colPh_r;
          ras_nxt = colPh_r; // RL15
          if (colPh_r) begin
            initCnt_nxt = initCnt_r + `DRAMC_ONE4;
            if (initCnt_r == `DRAMC_INIT_CYCLES - `DRAMC_ONE4) begin
              state_nxt = ST_PRE; // RL13
              init_nxt = 1'b1;
            end
          end
        end
      end
      ST_IDLE: begin
        if (idleExpired) begin
          state_nxt = ST_INIT; // RL14
          init_nxt = 1'b0;
          initCnt_nxt = `DRAMC_ZERO4;
          colPh_nxt = 1'b0;
        end else if (rfshDue) begin
          cas_nxt = 1'b0; // RL1
          state_nxt = ST_CBR; // RL2
          colPh_nxt = 1'b0;
        end else if (reqValid) begin
          addr_nxt = reqRow; // RL10
          colAddr_nxt = reqCol;
          we_nxt = !reqWrite;
          din_nxt = reqWData;
          rd_nxt = !reqWrite;
          last_nxt = reqLast;
          colPh_nxt = 1'b0;
          state_nxt = ST_ROW;
        end
      end
      ST_ROW: begin
        if (tmrIf.done) begin
          colPh_nxt = !colPh_r;
          if (!colPh_r) begin
            ras_nxt = 1'b0; // RL6
          end else begin
            addr_nxt = colAddr_r; // RL10
            state_nxt = ST_COL;
          end
        end
      end
      ST_COL: begin
        if (tmrIf.done) begin
          colPh_nxt = !colPh_r;
          if (!colPh_r) begin
            cas_nxt = 1'b0; // RL11
          end else begin
            if (rd_r) begin
              rdat_nxt = dq2_r;
            end
            rsp_nxt = 1'b1;
            we_nxt = 1'b1;
            if (rd_r && rfshDue) begin
              // Column strobe stays low so the read data stays driven
              ras_nxt = 1'b1; // RL4
              state_nxt = ST_HIDDEN;
            end else begin
              cas_nxt = 1'b1;
              state_nxt = ST_PAGE; // RL10
            end
          end
        end
      end
      ST_PAGE: begin
        // Row stays open for further columns in any read/write mix
        if (last_r || rfshDue) begin
          ras_nxt = 1'b1;
          state_nxt = ST_PRE;
        end else if (reqValid) begin
          addr_nxt = reqCol; // RL11
          we_nxt = !reqWrite; // RL12
          din_nxt = reqWData;
          rd_nxt = !reqWrite;
          last_nxt = reqLast;
          colPh_nxt = 1'b0;
          state_nxt = ST_COL;
        end
      end
      ST_CBR: begin
        if (tmrIf.done) begin
          colPh_nxt = !colPh_r;
          if (!colPh_r) begin
            ras_nxt = 1'b0; // RL3
          end else begin
            ras_nxt = 1'b1;
            cas_nxt = 1'b1;
            pend_nxt = 1'b0; // RL18
            state_nxt = ST_PRE;
          end
        end
      end
      ST_HIDDEN: begin
        if (tmrIf.done) begin
          colPh_nxt = !colPh_r;
          if (!colPh_r) begin
            ras_nxt = 1'b0; // RL4
          end else begin
            ras_nxt = 1'b1;
            cas_nxt = 1'b1;
            pend_nxt = 1'b0;
            state_nxt = ST_PRE;
          end
        end
      end
      ST_PRE: begin
        if (tmrIf.done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_PAUSE;
      end
    endcase
    // Placed last so a new tick beats a same-cycle clear
    if (rfsh_r >= RFSH_INT_CYC - 1) begin
      rfsh_nxt = `DRAMC_ZERO32;
      pend_nxt = 1'b1; // RL17
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r   <= ST_PAUSE;
      ras_r     <= 1'b1; // RL16
      cas_r     <= 1'b1; // RL16
      we_r      <= 1'b1;
      addr_r    <= `DRAMC_ZERO_ADDR;
      colAddr_r <= `DRAMC_ZERO_ADDR;
      din_r     <= 1'b0;
      rd_r      <= 1'b0;
      last_r    <= 1'b0;
      rsp_r     <= 1'b0;
      rdat_r    <= 1'b0;
      init_r    <= 1'b0;
      pend_r    <= 1'b0;
      colPh_r   <= 1'b0;
      initCnt_r <= `DRAMC_ZERO4;
      wait_r    <= `DRAMC_ZERO32;
      rfsh_r    <= `DRAMC_ZERO32;
      idle_r    <= `DRAMC_ZERO32;
    end else begin
      state_r   <= state_nxt;
      ras_r     <= ras_nxt;
      cas_r     <= cas_nxt;
      we_r      <= we_nxt;
      addr_r    <= addr_nxt;
      colAddr_r <= colAddr_nxt;
      din_r     <= din_nxt;
      rd_r      <= rd_nxt;
      last_r    <= last_nxt;
      rsp_r     <= rsp_nxt;
      rdat_r    <= rdat_nxt;
      init_r    <= init_nxt;
      pend_r    <= pend_nxt;
      colPh_r   <= colPh_nxt;
      initCnt_r <= initCnt_nxt;
      wait_r    <= wait_nxt;
      rfsh_r    <= rfsh_nxt;
      idle_r    <= idle_nxt;
    end
  end
endmodule // dramc_ctrl
`default_nettype wire

// [verif/dramc_ctrl_properties.sv]
// Port checks for the DRAM strobe controller
`timescale 1ns/10ps
`default_nettype none
module dramc_ctrl_properties
  import dramc_pkg::*;
#(
  parameter int PAUSE_CYC    = 40,
  parameter int IDLE_CYC     = 4000,
  parameter int RFSH_INT_CYC = 200
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic reqReady,
  input wire logic rspValid,
  input wire logic initDone,
  input wire logic rowStrobeN,
  input wire logic colStrobeN
);
  // ======
  // Helpers
  logic [31:0] cyc_r;
  logic [31:0] gap_r;
  logic [3:0]  ras_r;
  always_ff @(posedge clk) begin
    cyc_r <= rst ? 32'h0000_0000 : cyc_r + 32'h0000_0001;
    gap_r <= (rst || !rowStrobeN) ? 32'h0000_0000 : gap_r + 32'h0000_0001;
    ras_r <= rst ? 4'h0 : ras_r + {3'h0, ($rose(rowStrobeN) && ras_r != 4'hf)};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_pause_strobes_high: assert property (cyc_r < PAUSE_CYC |-> rowStrobeN && colStrobeN)
    else $error("strobe active during pause");
  a_init_after_pause: assert property (initDone |-> cyc_r >= PAUSE_CYC)
    else $error("init done before pause ended");
  a_init_eight_cycles: assert property ($rose(initDone) |=> ras_r >= 4'h8)
    else $error("init done with too few row cycles");
  a_ready_after_init: assert property (reqReady |-> initDone)
    else $error("request accepted before init");
  a_refresh_gap: assert property (initDone |-> gap_r < IDLE_CYC)
    else $error("row strobe idle too long");
  a_row_low_min: assert property ($fell(rowStrobeN) |-> !rowStrobeN[*2])
    else $error("row strobe pulse too short");
  a_row_precharge: assert property ($rose(rowStrobeN) |-> rowStrobeN[*2])
    else $error("row precharge too short");
  a_col_pulse: assert property ($fell(colStrobeN) |-> !colStrobeN[*2])
    else $error("column strobe pulse too short");
  a_rsp_col_low: assert property (rspValid |-> $past(!colStrobeN))
    else $error("read data without column strobe");
  c_init: cover property ($rose(initDone));
  c_cbr: cover property ($fell(rowStrobeN) && !colStrobeN);
  c_read: cover property (rspValid);
  c_hidden: cover property ($rose(rowStrobeN) && !colStrobeN);
endmodule // dramc_ctrl_properties
bind dramc_ctrl dramc_ctrl_properties #(.PAUSE_CYC(PAUSE_CYC), .IDLE_CYC(IDLE_CYC),
  .RFSH_INT_CYC(RFSH_INT_CYC)) u_props (.clk(clk), .rst(rst), .reqReady(reqReady),
  .rspValid(rspValid), .initDone(initDone), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN));
`default_nettype wire

// [verif/dramc_mem_model.sv]
// Behavioural model of the 1M x 1 dynamic RAM
`timescale 1ns/10ps
`default_nettype none
module dramc_mem_model
  import dramc_pkg::*;
(
  // Strobes, address, data in
  input  wire logic       rowStrobeN,
  input  wire logic       colStrobeN,
  input  wire logic       writeEnN,
  input  wire logic [9:0] memAddr,
  input  wire logic       memDIn,
  // Data out and row cycle count
  output logic            memDOut,
  output int              rowCycles
);
  logic       mem [bit [19:0]];
  logic [9:0] row_r;
  logic [8:0] rfsh_r;
  logic       last_r;
  initial begin
    rfsh_r = 9'h000;
    rowCycles = 0;
    last_r = 1'b0;
    memDOut = 1'b1;
  end
  always @(negedge rowStrobeN) begin
    rowCycles = rowCycles + 1;
    if (!colStrobeN) begin
      row_r = {1'b1, rfsh_r};
      rfsh_r = rfsh_r + 9'h001;
    end else begin
      row_r = memAddr;
    end
  end
  always @(negedge colStrobeN) if (!rowStrobeN) begin
    if (!writeEnN) begin
      mem[{row_r, memAddr}] = memDIn;
    end else begin
      last_r = mem.exists({row_r, memAddr}) ? mem[{row_r, memAddr}] : 1'b0;
      memDOut = last_r;
    end
  end
  // Late write under a low column strobe
  always @(negedge writeEnN) if (!rowStrobeN && !colStrobeN) mem[{row_r, memAddr}] = memDIn;
  // Released output shows no stale value
  always @(posedge colStrobeN) memDOut = ~last_r;
endmodule // dramc_mem_model
`default_nettype wire

// [verif/dramc_ctrl_tb.sv]
// Self-checking bench for the DRAM strobe controller
`timescale 1ns/10ps
`default_nettype none
module dramc_ctrl_tb;
  import dramc_pkg::*;
  logic clk, rst, reqValid, reqReady, reqWrite, reqWData, reqLast;
  logic rspValid, rspRData, initDone, rowStrobeN, colStrobeN, writeEnN, memDIn, memDOut;
  logic [9:0] reqRow, reqCol, memAddr;
  int rowCycles, errors, samplesChecked, cycles;
  dramc_ctrl #(.PAUSE_CYC(40), .IDLE_CYC(4000), .RFSH_INT_CYC(200)) dut (.clk(clk),
    .rst(rst), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
    .reqRow(reqRow), .reqCol(reqCol), .reqWData(reqWData), .reqLast(reqLast),
    .rspValid(rspValid), .rspRData(rspRData), .initDone(initDone),
    .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnN(writeEnN),
    .memAddr(memAddr), .memDIn(memDIn), .memDOut(memDOut));
  dramc_mem_model u_mem (.rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
    .writeEnN(writeEnN), .memAddr(memAddr), .memDIn(memDIn), .memDOut(memDOut),
    .rowCycles(rowCycles));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ======
  // Checking and closing
  task automatic chk(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard well above the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  // ======
  // Request port
  task automatic req(input logic w, input logic [9:0] r, c, input logic d, l);
    int n;
    n = 0;
    @(posedge clk);
    #1 reqValid = 1'b1;
    reqWrite = w;
    reqRow = r;
    reqCol = c;
    reqWData = d;
    reqLast = l;
    @(negedge clk);
    while (reqReady !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    #1 reqValid = 1'b0;
    if (n == 500) chk(1'b0, 1'b1);
  endtask
  task automatic rd(input logic [9:0] r, c, input logic l, exp);
    int n;
    n = 0;
    req(1'b0, r, c, 1'b0, l);
    while (rspValid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) chk(1'b0, 1'b1);
    chk(rspRData, exp);
  endtask
  // ======
  // Scenarios
  task automatic t_init();
    int n;
    n = 0;
    while (initDone !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(initDone, 1'b1);
    $display("init test done");
  endtask
  task automatic t_page();
    for (int i = 0; i < 4; i++) req(1'b1, 10'h005, 10'(i), i[0], 1'b0);
    rd(10'h005, 10'h000, 1'b0, 1'b0);
    req(1'b1, 10'h005, 10'h004, 1'b1, 1'b0);
    rd(10'h005, 10'h004, 1'b0, 1'b1);
    rd(10'h005, 10'h003, 1'b1, 1'b1);
    $display("page test done");
  endtask
  task automatic t_rows();
    req(1'b1, 10'h3ff, 10'h007, 1'b1, 1'b1);
    req(1'b1, 10'h1ff, 10'h007, 1'b0, 1'b1);
    rd(10'h3ff, 10'h007, 1'b1, 1'b1);
    rd(10'h1ff, 10'h007, 1'b1, 1'b0);
    $display("row test done");
  endtask
  task automatic t_refresh();
    int n0;
    n0 = rowCycles;
    repeat (700) @(posedge clk);
    chk(rowCycles >= n0 + 3, 1'b1);
    rd(10'h005, 10'h001, 1'b1, 1'b1);
    $display("refresh test done");
  endtask
  initial begin
    {errors, samplesChecked, cycles} = '0;
    {reqValid, reqWrite, reqWData, reqLast} = 4'h0;
    reqRow = 10'h000;
    reqCol = 10'h000;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_init();
    t_page();
    t_rows();
    t_refresh();
    give_verdict();
  end
endmodule // dramc_ctrl_tb
`default_nettype wire
